//--- core/ssl_pkg.sv
// shared constants and types for the synthesizer serial load block
package ssl_pkg;
    localparam int WORD_W = 24;
    localparam int SEL_W  = 2;
    // latch select codes in the two lsbs of each word
    localparam logic [1:0] SEL_REF  = 2'h0;
    localparam logic [1:0] SEL_AB   = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;
    // field positions inside function and initialization words
    localparam int HOLD_POS    = 2;
    localparam int PD_REQ_POS  = 3;
    localparam int PD_SYNC_POS = 21;
    localparam int CP_TRI_POS  = 8;
    localparam int CNT_W       = 5;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
    // settle time after enable rises, kept as a figure in ns
    localparam int SETTLE_NS    = 1000;
    localparam int CLK_NS       = 4;
    localparam int SETTLE_CYC_I = SETTLE_NS / CLK_NS;
    localparam logic [8:0] SETTLE_CYC = SETTLE_CYC_I[8:0];

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic strobe;
        logic chip_en;
    } ssl_pins_s;

    typedef struct packed {
        logic [WORD_W-1:0] ref_latch;
        logic [WORD_W-1:0] ab_latch;
        logic [WORD_W-1:0] func_latch;
        logic [WORD_W-1:0] init_latch;
    } ssl_latches_s;

    function automatic logic [3:0] ssl_sel_decode(logic [1:0] sel);
        ssl_sel_decode = 4'h1 << sel;
    endfunction
endpackage

//--- core/ssl_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module ssl_sync #(
    parameter int W = 4
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule

//--- core/ssl_shift.sv
// serial input shift register clocked by detected serial clock edges
`timescale 1ns/100ps
module ssl_shift
    import ssl_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              shift_en,
    input  wire logic              bit_in,
    output logic      [WORD_W-1:0] word
);
    logic [WORD_W-1:0] sr_q;
    logic [WORD_W-1:0] sr_d;

    always_comb begin
        sr_d = sr_q;
        if (shift_en) begin
            sr_d = {sr_q[WORD_W-2:0], bit_in};
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sr_q <= WORD_RST;
        end else begin
            sr_q <= sr_d;
        end
    end

    assign word = sr_q;
endmodule

//--- core/ssl_top.sv
// serial latch loading, counter reset pulse and power-down control
`timescale 1ns/100ps

module ssl_top
    import ssl_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                serial_clk,
    input  wire logic                serial_data,
    input  wire logic                latch_load_strobe,
    input  wire logic                chip_enable,
    input  wire logic                cp_event,
    output logic      [WORD_W-1:0]   ref_latch,
    output logic      [WORD_W-1:0]   ab_latch,
    output logic      [WORD_W-1:0]   func_latch,
    output logic      [WORD_W-1:0]   init_latch,
    output logic                     counter_reset_pulse,
    output logic                     counters_held,
    output logic                     cp_tristate,
    output logic                     powered_down,
    output logic                     settled,
    output logic                     latch_written
);
    import ssl_pkg::*;

    ssl_pins_s pins_raw;
    ssl_pins_s pins_s;
    logic [WORD_W-1:0] word;
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic strobe_prev_q;
    logic strobe_prev_d;
    logic sclk_rise;
    logic strobe_rise;
    logic [3:0] sel_hot;

    always_comb begin
        pins_raw.sclk    = serial_clk;
        pins_raw.sdata   = serial_data;
        pins_raw.strobe  = latch_load_strobe;
        pins_raw.chip_en = chip_enable;
    end

    // every pin but cp_event crosses from the host's timing through two flops
    ssl_sync #(
        .W ($bits(ssl_pins_s))
    ) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .din    (pins_raw),
        .dout   (pins_s)
    );

    // edge detectors look only at synchronised copies
    always_comb begin
        sclk_prev_d   = pins_s.sclk;
        strobe_prev_d = pins_s.strobe;
        sclk_rise     = pins_s.sclk & ~sclk_prev_q;
        strobe_rise   = pins_s.strobe & ~strobe_prev_q;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sclk_prev_q   <= 1'b0;
            strobe_prev_q <= 1'b0;
        end else begin
            sclk_prev_q   <= sclk_prev_d;
            strobe_prev_q <= strobe_prev_d;
        end
    end

    // data is sampled at the same synchronised edge, delayed equally
    ssl_shift u_shift (
        .mclk     (mclk),
        .resetn   (resetn),
        .shift_en (sclk_rise),
        .bit_in   (pins_s.sdata),
        .word     (word)
    );

    assign sel_hot = ssl_sel_decode(word[SEL_W-1:0]);

    // latch file: only a strobe rise moves a word
    ssl_latches_s lat_q;
    ssl_latches_s lat_d;
    logic wr_q;
    logic wr_d;

    always_comb begin
        lat_d = lat_q;
        wr_d  = 1'b0;
        // nothing moves unless the strobe has just risen
        if (strobe_rise) begin
            wr_d = 1'b1;
            if (sel_hot[SEL_INIT]) begin
                lat_d.init_latch = word;
                lat_d.func_latch = word;
            end
            if (sel_hot[SEL_FUNC]) begin
                lat_d.func_latch = word;
            end
            if (sel_hot[SEL_REF]) begin
                lat_d.ref_latch = word;
            end
            if (sel_hot[SEL_AB]) begin
                lat_d.ab_latch = word;
            end
        end
    end

    // latches have no clear but reset; enable never touches them
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lat_q <= '0;
            wr_q  <= 1'b0;
        end else begin
            lat_q <= lat_d;
            wr_q  <= wr_d;
        end
    end

    // counter reset pulse: init write, then the first ab load only
    logic ab_armed_q;
    logic ab_armed_d;
    logic pulse_q;
    logic pulse_d;

    always_comb begin
        ab_armed_d = ab_armed_q;
        pulse_d    = 1'b0;
        if (strobe_rise && sel_hot[SEL_INIT]) begin
            pulse_d    = 1'b1;
            ab_armed_d = 1'b1;
        end
        // a later init write re-arms; other ab loads stay quiet
        if (strobe_rise && sel_hot[SEL_AB] && ab_armed_q) begin
            pulse_d    = 1'b1;
            ab_armed_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ab_armed_q <= 1'b0;
            pulse_q    <= 1'b0;
        end else begin
            ab_armed_q <= ab_armed_d;
            pulse_q    <= pulse_d;
        end
    end

    // power-down state machine
    typedef enum logic [1:0] {
        PD_RUN,
        PD_WAIT_CP,
        PD_DOWN
    } ssl_pd_e;

    ssl_pd_e pd_q;
    ssl_pd_e pd_d;
    logic pd_req;
    logic pd_sync;
    logic hold;
    logic cp_tri_bit;
    logic pwr_dn;

    // programmed controls are read back from the function latch
    always_comb begin
        pd_req     = lat_q.func_latch[PD_REQ_POS];
        pd_sync    = lat_q.func_latch[PD_SYNC_POS];
        hold       = lat_q.func_latch[HOLD_POS];
        cp_tri_bit = lat_q.func_latch[CP_TRI_POS];
        // enable low overrides every programmed mode
        pwr_dn     = !pins_s.chip_en || (pd_q == PD_DOWN);
    end

    always_comb begin
        pd_d = pd_q;
        case (pd_q)
            PD_RUN: begin
                // only the counter reset pulse (init write or first ab load after it) arms a synchronous power-down
                if (pulse_q && pd_req && pd_sync) begin
                    pd_d = PD_WAIT_CP;
                end else if (pd_req && !pd_sync) begin
                    pd_d = PD_DOWN;
                end
            end
            PD_WAIT_CP: begin
                if (!pd_req) begin
                    pd_d = PD_RUN;
                end else if (cp_event) begin
                    pd_d = PD_DOWN;
                end
            end
            PD_DOWN: begin
                if (!pd_req) begin
                    pd_d = PD_RUN;
                end
            end
            default: pd_d = PD_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pd_q <= PD_RUN;
        end else begin
            pd_q <= pd_d;
        end
    end

    // settle counter: 1 us of mclk cycles after power-down ends
    logic [8:0] settle_q;
    logic [8:0] settle_d;

    // counters leave load point together on enable rise
    always_comb begin
        if (pwr_dn) begin
            settle_d = '0;
        end else if (settle_q != SETTLE_CYC) begin
            settle_d = settle_q + 9'h001;
        end else begin
            settle_d = settle_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            settle_q <= '0;
        end else begin
            settle_q <= settle_d;
        end
    end

    // output status flags, each straight from its own flop
    logic held_q;
    logic held_d;
    logic tri_q;
    logic tri_d;
    logic pdo_q;
    logic pdo_d;
    logic set_q;
    logic set_d;

    always_comb begin
        pdo_d  = pwr_dn;
        held_d = pwr_dn || hold || pulse_q;
        tri_d  = held_d || cp_tri_bit;
        set_d  = !pwr_dn && (settle_q == SETTLE_CYC);
    end

    // come out of reset halted and three-stated, as if powered down
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            held_q <= 1'b1;
            tri_q  <= 1'b1;
            pdo_q  <= 1'b1;
            set_q  <= 1'b0;
        end else begin
            held_q <= held_d;
            tri_q  <= tri_d;
            pdo_q  <= pdo_d;
            set_q  <= set_d;
        end
    end

    assign ref_latch           = lat_q.ref_latch;
    assign ab_latch            = lat_q.ab_latch;
    assign func_latch          = lat_q.func_latch;
    assign init_latch          = lat_q.init_latch;
    assign counter_reset_pulse = pulse_q;
    assign counters_held       = held_q;
    assign cp_tristate         = tri_q;
    assign powered_down        = pdo_q;
    assign settled             = set_q;
    assign latch_written       = wr_q;
endmodule

//--- tb/ssl_host.sv
// host serial master model driving the three-wire load pins
`timescale 1ns/100ps
module ssl_host (
    input  wire logic mclk,
    output logic      sclk,
    output logic      sdata,
    output logic      strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        strobe = 1'b0;
    end
    // half a 64 ns link period, moved just after an mclk rise
    task automatic half();
        repeat (8) @(posedge mclk);
        #1;
    endtask
    // msb first; three bytes in a row give the same bit stream
    task automatic send(input logic [23:0] w, input logic ld);
        for (int i = 23; i >= 0; i--) begin
            sdata = w[i];
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        // data no longer valid: show its inverse, clock stands still
        sdata = ~sdata;
        half();
        strobe = ld;
        half();
        strobe = 1'b0;
    endtask
endmodule

//--- tb/ssl_top_monitor.sv
// port assertions for the synthesizer serial load block
`timescale 1ns/100ps
module ssl_top_monitor
    import ssl_pkg::*;
(
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic              chip_enable,
    input wire logic [WORD_W-1:0] ref_latch,
    input wire logic [WORD_W-1:0] ab_latch,
    input wire logic [WORD_W-1:0] func_latch,
    input wire logic [WORD_W-1:0] init_latch,
    input wire logic              counter_reset_pulse,
    input wire logic              counters_held,
    input wire logic              cp_tristate,
    input wire logic              powered_down,
    input wire logic              latch_written
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence pulse_s;
        counter_reset_pulse && latch_written ##1 !counter_reset_pulse;
    endsequence
    sequence halted_s;
        counters_held && cp_tristate;
    endsequence
    reset_pulse_a:
        assert property (counter_reset_pulse |-> pulse_s)
        else $error("reset pulse shape wrong");
    pulse_halts_a:
        assert property (counter_reset_pulse |=> halted_s)
        else $error("pulse did not halt counters");
    hold_bit_a:
        assert property (func_latch[HOLD_POS] &&
            $past(func_latch[HOLD_POS]) |-> halted_s)
        else $error("hold bit did not halt counters");
    latch_keep_a:
        assert property (!latch_written |-> $stable({ref_latch,
            ab_latch, func_latch, init_latch}))
        else $error("latch changed without a load");
    init_copy_a:
        assert property (latch_written && $changed(init_latch)
            |-> func_latch == init_latch)
        else $error("init write not copied to function");
    ce_off_a:
        assert property ($fell(chip_enable) |-> ##[1:5] powered_down)
        else $error("enable low did not power down");
    pd_halts_a:
        assert property (powered_down |-> ##[0:1] halted_s)
        else $error("power-down left counters running");
    hold_no_pd_a:
        assert property ($rose(func_latch[HOLD_POS]) && chip_enable &&
            !func_latch[PD_REQ_POS] && !powered_down |=> !powered_down)
        else $error("hold bit caused power-down");
endmodule

//--- tb/ssl_top_tb.sv
// self-checking bench for the serial load block with host model
`timescale 1ns/100ps
module ssl_top_tb;
    import ssl_pkg::*;
    logic         mclk, resetn, chip_enable, cp_event;
    logic         serial_clk, serial_data, latch_load_strobe;
    logic         counter_reset_pulse, counters_held, cp_tristate;
    logic         powered_down, settled, latch_written;
    ssl_latches_s lat;
    ssl_latches_s m = '0;
    ssl_latches_s q_lat[$];
    logic         q_pls[$];
    logic         armed = 1'b0;
    logic [23:0]  extra = 24'h000000;
    logic [31:0]  rs = 32'h00005720;
    int           n_fail = 0;
    int           cmp_count = 0;
    int           cyc = 0;

    ssl_top dut (.mclk, .resetn, .serial_clk, .serial_data,
        .latch_load_strobe, .chip_enable, .cp_event,
        .ref_latch(lat.ref_latch), .ab_latch(lat.ab_latch),
        .func_latch(lat.func_latch), .init_latch(lat.init_latch),
        .counter_reset_pulse, .counters_held, .cp_tristate,
        .powered_down, .settled, .latch_written);
    ssl_host host (.mclk, .sclk(serial_clk), .sdata(serial_data),
        .strobe(latch_load_strobe));

    always #2 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction

    task automatic chk(input string nm, input logic [95:0] e,
                       input logic [95:0] g);
        cmp_count++;
        if (e !== g) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // random word; only extra sets power-down and three-state bits
    task automatic wr(input logic [1:0] sel, input logic hold,
                      input logic ld);
        logic [23:0] w;
        logic        p;
        rs = xs(rs);
        w = (rs[23:0] & 24'hdffef0) | extra | {21'h0, hold, sel};
        p = 1'b0;
        if (ld) begin
            case (sel)
                2'h0: m.ref_latch = w;
                2'h1: begin
                    m.ab_latch = w;
                    p = armed;
                    armed = 1'b0;
                end
                2'h2: m.func_latch = w;
                default: begin
                    m.init_latch = w;
                    m.func_latch = w;
                    p = 1'b1;
                    armed = 1'b1;
                end
            endcase
            q_lat.push_back(m);
            q_pls.push_back(p);
        end
        host.send(w, ld);
        repeat (8) @(posedge mclk);
        #1;
    endtask

    // oldest note is taken off whenever a load shows up
    // falling edge: outputs launched at the rise have settled
    always @(negedge mclk) begin
        cyc++;
        if (resetn && latch_written === 1'b1) begin
            if (q_lat.size() == 0) begin
                n_fail++;
                $display("Error latch_written expected 0 seen 1");
            end else begin
                chk("latches", q_lat.pop_front(), lat);
                chk("pulse", q_pls.pop_front(), counter_reset_pulse);
            end
        end
        if (cyc > 12000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        chip_enable = 1'b1;
        cp_event = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        resetn = 1'b1;
        @(posedge mclk);
        #1;
        wr(2'h3, 1'b0, 1'b1);
        wr(2'h2, 1'b0, 1'b1);
        wr(2'h0, 1'b0, 1'b1);
        wr(2'h1, 1'b0, 1'b1);
        wr(2'h1, 1'b0, 1'b1);
        wr(2'h0, 1'b0, 1'b0);
        chk("held", 1'b0, counters_held);
        wr(2'h2, 1'b1, 1'b1);
        chk("held", 1'b1, counters_held);
        chk("cp_tristate", 1'b1, cp_tristate);
        wr(2'h0, 1'b0, 1'b1);
        wr(2'h1, 1'b0, 1'b1);
        chk("powered_down", 1'b0, powered_down);
        wr(2'h2, 1'b0, 1'b1);
        chk("held", 1'b0, counters_held);
        // sync power-down armed by the init pulse, taken on a cp event
        extra = 24'h200008;
        wr(2'h3, 1'b0, 1'b1);
        chk("powered_down", 1'b0, powered_down);
        cp_event = 1'b1;
        @(posedge mclk);
        #1;
        cp_event = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("powered_down", 1'b1, powered_down);
        chk("held", 1'b1, counters_held);
        extra = 24'h000100;
        wr(2'h2, 1'b0, 1'b1);
        chk("powered_down", 1'b0, powered_down);
        chk("held", 1'b0, counters_held);
        chk("cp_tristate", 1'b1, cp_tristate);
        extra = 24'h000008;
        wr(2'h2, 1'b0, 1'b1);
        chk("powered_down", 1'b1, powered_down);
        extra = 24'h000000;
        wr(2'h2, 1'b0, 1'b1);
        chk("powered_down", 1'b0, powered_down);
        chip_enable = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        chk("powered_down", 1'b1, powered_down);
        wr(2'h2, 1'b0, 1'b1);
        wr(2'h0, 1'b0, 1'b1);
        wr(2'h1, 1'b0, 1'b1);
        chip_enable = 1'b1;
        // settle is 1000 ns of 4 ns cycles after power-down ends
        repeat (245) @(posedge mclk);
        #1;
        chk("settled", 1'b0, settled);
        repeat (15) @(posedge mclk);
        #1;
        chk("settled", 1'b1, settled);
        chk("held", 1'b0, counters_held);
        chk("latches", m, lat);
        report_and_stop();
    end
endmodule

bind ssl_top ssl_top_monitor u_mon (.mclk, .resetn, .chip_enable,
    .ref_latch, .ab_latch, .func_latch, .init_latch,
    .counter_reset_pulse, .counters_held, .cp_tristate,
    .powered_down, .latch_written);
